// ### core/tdm_serial_port_config.sv
// Port descriptor, guard descriptor and the line timing the port descriptor steers for one TDM serial port
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Guard bounds are stored, twelve bits each, and never checked against anything.
// - One port descriptor steers both receive and transmit directions.
// - Bit 9 clear, group enabled: unmapped transmit slots float the data output.
// - Bit 9 set, group enabled: unmapped transmit slots drive logic one.
// - Bit 8 picks the receive clock edge sampling the out-of-frame input.
// - Bit 7 picks the receive clock edge sampling receive frame sync.
// - Bit 6 picks the receive clock edge sampling receive serial data.
// - Bit 5 picks the transmit clock edge sampling transmit frame sync.
// - Bit 4 picks the transmit clock edge launching transmit serial data.
// - Mode 0 is T1 with 24 slots per frame.
// - Mode 1 is E1 with 32 slots per frame.
// - Mode 2 is double E1 with 64 slots per frame.
// - Mode 3 is quad E1 with 128 slots per frame.
// - Mode 4 drops flywheel and alignment-change detection; each sync zeroes the slot counter.
// - Transmitter disabled: every slot disabled, output floats, map bits untouched.
module tdm_serial_port_config (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  input  wire logic        rx_line_clock_in,
  input  wire logic        rx_serial_data_in,
  input  wire logic        rx_frame_sync_input_in,
  input  wire logic        out_of_frame_input_in,
  input  wire logic        tx_line_clock_in,
  input  wire logic        tx_frame_sync_input_in,
  output logic             tx_serial_data_out,
  output logic             tx_serial_data_oe_out,
  input  wire logic        tx_bit_in,
  output logic             tx_bit_take_out,
  output logic             rx_bit_out,
  output logic             rx_bit_valid_out,
  output logic      [6:0]  rx_slot_out
);
  import tdm_port_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [9:0] frame_last_bit(input logic [2:0] mode);
    unique case (mode)
      MODE_T1:   frame_last_bit = T1_LAST_BIT;
      MODE_E1:   frame_last_bit = E1_LAST_BIT;
      MODE_E1X2: frame_last_bit = E1X2_LAST_BIT;
      MODE_E1X4: frame_last_bit = E1X4_LAST_BIT;
      default:   frame_last_bit = E1X4_LAST_BIT;
    endcase
  endfunction : frame_last_bit

  // A sync hit makes the bit taken with it bit 0 of slot 0
  function automatic logic [9:0] next_pos(input logic [9:0] pos, input logic [9:0] last,
                                          input logic hit, input logic take);
    if (hit) begin
      next_pos = take ? 10'h001 : 10'h000;
    end else if (take) begin
      next_pos = (pos >= last) ? 10'h000 : 10'(pos + 10'h001);
    end else begin
      next_pos = pos;
    end
  endfunction : next_pos

  function automatic logic edge_pick(input logic rising, input logic rise, input logic fall);
    edge_pick = rising ? rise : fall;
  endfunction : edge_pick

  // ************************************************************
  // Line synchronisers
  // ************************************************************
  line_events_if #(.N(RX_LANES)) rx_ev ();
  line_events_if #(.N(TX_LANES)) tx_ev ();

  line_edge_finder #(.N(RX_LANES)) rx_finder (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .line_clk_in (rx_line_clock_in),
    .line_in     ({out_of_frame_input_in, rx_frame_sync_input_in, rx_serial_data_in}),
    .ev          (rx_ev.source)
  );

  line_edge_finder #(.N(TX_LANES)) tx_finder (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .line_clk_in (tx_line_clock_in),
    .line_in     (tx_frame_sync_input_in),
    .ev          (tx_ev.source)
  );

  // ************************************************************
  // Registers
  // ************************************************************
  logic [31:0] memory_guard_descriptor;
  logic [31:0] serial_port_descriptor;
  logic [31:0] control;
  logic [31:0] tx_map [TX_MAP_WORDS];
  logic        align_change;
  logic        oof_state;
  logic [9:0]  rx_pos;
  logic [9:0]  tx_pos;

  wire         wr_guard   = reg_wr_in && (reg_addr_in == GUARD_OFFSET);
  wire         wr_port    = reg_wr_in && (reg_addr_in == PORT_OFFSET);
  wire         wr_control = reg_wr_in && (reg_addr_in == CONTROL_OFFSET);
  wire         wr_status  = reg_wr_in && (reg_addr_in == STATUS_OFFSET);
  wire         map_hit    = (reg_addr_in[7:4] == TX_MAP_PAGE) && (reg_addr_in[1:0] == 2'b00);
  wire  [1:0]  map_index  = reg_addr_in[3:2];

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      memory_guard_descriptor <= REG_RESET;
      serial_port_descriptor  <= REG_RESET;
      control                 <= REG_RESET;
    end else begin
      if (wr_guard) begin
        memory_guard_descriptor <= reg_wdata_in & GUARD_WRITE_MASK;
      end
      if (wr_port) begin
        serial_port_descriptor <= reg_wdata_in & PORT_WRITE_MASK;
      end
      if (wr_control) begin
        control <= reg_wdata_in & CONTROL_MASK;
      end
    end
  end

  // Map bits are only written by software; disabling the transmitter leaves them alone
  genvar w;
  generate
    for (w = 0; w < TX_MAP_WORDS; w++) begin : g_map
      always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
          tx_map[w] <= REG_RESET;
        end else if (reg_wr_in && map_hit && (map_index == 2'(w))) begin
          tx_map[w] <= reg_wdata_in;
        end
      end
    end
  endgenerate

  wire  [2:0]  port_mode  = serial_port_descriptor[PORT_MODE_LSB +: 3];
  wire         flywheel   = ~port_mode[2];
  wire  [9:0]  frame_last = frame_last_bit(port_mode);
  wire         rx_enable  = control[RX_ENABLE_BIT];
  wire         tx_enable  = control[TX_ENABLE_BIT];
  wire         drive_one  = serial_port_descriptor[UNMAPPED_SLOT_OUTPUT_BIT];

  wire  [31:0] status_word = {9'h000, tx_pos[9:3], 1'b0, rx_pos[9:3], 6'h00, oof_state, align_change};
  wire  [31:0] read_value  = (reg_addr_in == GUARD_OFFSET)   ? memory_guard_descriptor :
                             (reg_addr_in == PORT_OFFSET)    ? serial_port_descriptor :
                             (reg_addr_in == CONTROL_OFFSET) ? control :
                             (reg_addr_in == STATUS_OFFSET)  ? status_word :
                             map_hit                         ? tx_map[map_index] : REG_RESET;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= REG_RESET;
    end else begin
      reg_rdata_out <= reg_rd_in ? read_value : REG_RESET;
    end
  end

  // ************************************************************
  // Receive timing
  // ************************************************************
  wire         rx_data_take = edge_pick(serial_port_descriptor[RX_DATA_EDGE_BIT],
                                        rx_ev.clk_rise, rx_ev.clk_fall);
  wire         rx_sync_take = edge_pick(serial_port_descriptor[RX_SYNC_EDGE_BIT],
                                        rx_ev.clk_rise, rx_ev.clk_fall);
  wire         oof_take     = edge_pick(serial_port_descriptor[OOF_EDGE_BIT],
                                        rx_ev.clk_rise, rx_ev.clk_fall);
  wire         rx_sync_hit  = rx_sync_take && rx_ev.level[RX_SYNC_LANE];
  wire  [9:0]  next_rx_pos  = next_pos(rx_pos, frame_last, rx_sync_hit, rx_data_take);
  wire  [6:0]  rx_cur_slot  = rx_sync_hit ? 7'h00 : rx_pos[9:3];
  // A sync off the expected boundary in a flywheel mode means the frame moved
  wire         frame_moved  = rx_sync_hit && flywheel && (rx_pos != 10'h000);

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rx_pos <= 10'h000;
    end else begin
      rx_pos <= next_rx_pos;
    end
  end

  // Set beats a clear arriving in the same cycle
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      align_change <= 1'b0;
    end else if (frame_moved) begin
      align_change <= 1'b1;
    end else if (wr_status && reg_wdata_in[ALIGN_CHANGE_BIT]) begin
      align_change <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      oof_state <= 1'b0;
    end else if (oof_take) begin
      oof_state <= rx_ev.level[RX_OOF_LANE];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rx_bit_out       <= 1'b0;
      rx_bit_valid_out <= 1'b0;
      rx_slot_out      <= 7'h00;
    end else begin
      rx_bit_valid_out <= rx_data_take && rx_enable;
      if (rx_data_take) begin
        rx_bit_out  <= rx_ev.level[RX_DATA_LANE];
        rx_slot_out <= rx_cur_slot;
      end
    end
  end

  // ************************************************************
  // Transmit timing
  // ************************************************************
  wire         tx_launch    = edge_pick(serial_port_descriptor[TX_DATA_EDGE_BIT],
                                        tx_ev.clk_rise, tx_ev.clk_fall);
  wire         tx_sync_take = edge_pick(serial_port_descriptor[TX_SYNC_EDGE_BIT],
                                        tx_ev.clk_rise, tx_ev.clk_fall);
  wire         tx_sync_hit  = tx_sync_take && tx_ev.level[TX_SYNC_LANE];
  wire  [9:0]  next_tx_pos  = next_pos(tx_pos, frame_last, tx_sync_hit, tx_launch);
  wire  [6:0]  tx_cur_slot  = tx_sync_hit ? 7'h00 : tx_pos[9:3];
  wire         tx_mapped    = tx_map[tx_cur_slot[6:5]][tx_cur_slot[4:0]];

  assign tx_bit_take_out = tx_launch && tx_enable && tx_mapped;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tx_pos <= 10'h000;
    end else begin
      tx_pos <= next_tx_pos;
    end
  end

  // Data holds its last value while floating, so the pin only moves on a launch edge
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tx_serial_data_out    <= 1'b1;
      tx_serial_data_oe_out <= 1'b0;
    end else if (!tx_enable) begin
      tx_serial_data_oe_out <= 1'b0;
    end else if (tx_launch) begin
      if (tx_mapped) begin
        tx_serial_data_out    <= tx_bit_in;
        tx_serial_data_oe_out <= 1'b1;
      end else if (drive_one) begin
        tx_serial_data_out    <= 1'b1;
        tx_serial_data_oe_out <= 1'b1;
      end else begin
        tx_serial_data_oe_out <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence unmapped_launch_s;
    tx_launch && tx_enable && !tx_mapped;
  endsequence

  unmapped_float_a: assert property (unmapped_launch_s and !drive_one |=> !tx_serial_data_oe_out)
    else $error("unmapped slot did not float the output");
  unmapped_one_a: assert property (unmapped_launch_s and drive_one |=> tx_serial_data_oe_out && tx_serial_data_out)
    else $error("unmapped slot did not drive one");
  tx_off_float_a: assert property (!tx_enable |-> !tx_bit_take_out ##1 !tx_serial_data_oe_out)
    else $error("disabled transmitter drove the output");
  tx_launch_edge_a: assert property ($changed(tx_serial_data_out) |->
      $past(edge_pick(serial_port_descriptor[TX_DATA_EDGE_BIT], tx_ev.clk_rise, tx_ev.clk_fall)))
    else $error("transmit data moved off the launch edge");
  rx_data_edge_a: assert property (rx_bit_valid_out |->
      $past(edge_pick(serial_port_descriptor[RX_DATA_EDGE_BIT], rx_ev.clk_rise, rx_ev.clk_fall))
      && rx_bit_out == $past(rx_ev.level[RX_DATA_LANE]))
    else $error("receive bit not taken on the chosen edge");
  oof_edge_a: assert property ($changed(oof_state) |->
      $past(edge_pick(serial_port_descriptor[OOF_EDGE_BIT], rx_ev.clk_rise, rx_ev.clk_fall)))
    else $error("out-of-frame state moved off its edge");
  rx_sync_align_a: assert property (rx_ev.level[RX_SYNC_LANE] &&
      edge_pick(serial_port_descriptor[RX_SYNC_EDGE_BIT], rx_ev.clk_rise, rx_ev.clk_fall)
      |=> rx_pos <= 10'h001)
    else $error("receive sync did not realign the counter");
  tx_sync_align_a: assert property (tx_ev.level[TX_SYNC_LANE] &&
      edge_pick(serial_port_descriptor[TX_SYNC_EDGE_BIT], tx_ev.clk_rise, tx_ev.clk_fall)
      |=> tx_pos <= 10'h001)
    else $error("transmit sync did not realign the counter");
  frame_wrap_a: assert property (rx_data_take && !rx_sync_hit && rx_pos == frame_last |=> rx_pos == 10'h000)
    else $error("slot counter missed its frame wrap");
  t1_length_a: assert property (port_mode == MODE_T1 && rx_data_take && !rx_sync_hit
      && rx_pos == 10'd190 |=> rx_pos == 10'd191)
    else $error("T1 frame shorter than 24 slots");
  nx64_no_align_a: assert property (port_mode == MODE_NX64 && !align_change && !wr_status |=> !align_change)
    else $error("alignment change flagged in Nx64 mode");
  misalign_flag_a: assert property (rx_sync_hit && flywheel && rx_pos != 10'h000 |=> align_change)
    else $error("misaligned sync not flagged");

endmodule : tdm_serial_port_config
`default_nettype wire

// ### core/tdm_port_pkg.sv
// Constants, field layout and mode codes shared by the TDM serial port configuration block
package tdm_port_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0]  GUARD_OFFSET    = 8'h00;
  localparam logic [7:0]  PORT_OFFSET     = 8'h04;
  localparam logic [7:0]  CONTROL_OFFSET  = 8'h08;
  localparam logic [7:0]  STATUS_OFFSET   = 8'h0C;
  localparam logic [3:0]  TX_MAP_PAGE     = 4'h1;
  localparam int          TX_MAP_WORDS    = 4;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int          PROTECTION_ENABLE_BIT    = 31;
  localparam int          UNMAPPED_SLOT_OUTPUT_BIT = 9;
  localparam int          OOF_EDGE_BIT             = 8;
  localparam int          RX_SYNC_EDGE_BIT         = 7;
  localparam int          RX_DATA_EDGE_BIT         = 6;
  localparam int          TX_SYNC_EDGE_BIT         = 5;
  localparam int          TX_DATA_EDGE_BIT         = 4;
  localparam int          PORT_MODE_LSB            = 0;
  localparam int          RX_ENABLE_BIT            = 0;
  localparam int          TX_ENABLE_BIT            = 1;
  localparam int          MAPPING_LSB              = 2;
  localparam int          ALIGN_CHANGE_BIT         = 0;
  localparam int          OOF_STATE_BIT            = 1;
  localparam int          RX_SLOT_LSB              = 8;
  localparam int          TX_SLOT_LSB              = 16;

  // Writable bits; reserved bits are not stored and read back as zero
  localparam logic [31:0] GUARD_WRITE_MASK = 32'h8FFF_0FFF;
  localparam logic [31:0] PORT_WRITE_MASK  = 32'h0000_03F7;
  localparam logic [31:0] CONTROL_MASK     = 32'h0000_000F;
  localparam logic [31:0] REG_RESET        = 32'h0000_0000;

  // ************************************************************
  // Line lanes and framing
  // ************************************************************
  localparam int          RX_LANES      = 3;
  localparam int          RX_DATA_LANE  = 0;
  localparam int          RX_SYNC_LANE  = 1;
  localparam int          RX_OOF_LANE   = 2;
  localparam int          TX_LANES      = 1;
  localparam int          TX_SYNC_LANE  = 0;
  localparam int          BITS_PER_SLOT = 8;
  localparam int          T1_SLOTS      = 24;
  localparam int          E1_SLOTS      = 32;
  localparam int          E1X2_SLOTS    = 64;
  localparam int          E1X4_SLOTS    = 128;
  localparam logic [9:0]  T1_LAST_BIT   = 10'(T1_SLOTS * BITS_PER_SLOT - 1);
  localparam logic [9:0]  E1_LAST_BIT   = 10'(E1_SLOTS * BITS_PER_SLOT - 1);
  localparam logic [9:0]  E1X2_LAST_BIT = 10'(E1X2_SLOTS * BITS_PER_SLOT - 1);
  localparam logic [9:0]  E1X4_LAST_BIT = 10'(E1X4_SLOTS * BITS_PER_SLOT - 1);

  typedef enum logic [2:0] {
    MODE_T1   = 3'b000,
    MODE_E1   = 3'b001,
    MODE_E1X2 = 3'b010,
    MODE_E1X4 = 3'b011,
    MODE_NX64 = 3'b100
  } port_mode_type;

endpackage : tdm_port_pkg

// ### core/line_events_if.sv
// Edge pulses and settled levels of one serial line, seen in the core clock domain
`timescale 1ns/1ps
`default_nettype none
interface line_events_if #(parameter int N = 1);
  logic         clk_rise;
  logic         clk_fall;
  logic [N-1:0] level;
  modport source (output clk_rise, output clk_fall, output level);
  modport sink   (input clk_rise, input clk_fall, input level);
endinterface : line_events_if
`default_nettype wire

// ### core/line_edge_finder.sv
// Synchroniser and edge finder for one line clock and its companion inputs
`timescale 1ns/1ps
`default_nettype none
module line_edge_finder #(
  parameter int N = 1
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         line_clk_in,
  input  wire logic [N-1:0] line_in,
  line_events_if.source     ev
);

  // Lane 0 is the line clock, the others are the companion inputs
  logic [N:0] stage1;
  logic [N:0] stage2;
  logic [N:0] stage3;
  logic [N:0] settled;
  logic       clk_prev;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= {line_in, line_clk_in};
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A lane only moves once the second and third stages agree, so one bad sample never counts
  genvar g;
  generate
    for (g = 0; g <= N; g++) begin : g_lane
      always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
          settled[g] <= 1'b0;
        end else if (stage2[g] == stage3[g]) begin
          settled[g] <= stage3[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= settled[0];
    end
  end

  assign ev.clk_rise = settled[0] & ~clk_prev;
  assign ev.clk_fall = ~settled[0] & clk_prev;
  assign ev.level    = settled[N:1];

endmodule : line_edge_finder
`default_nettype wire

// ### tb/tdm_line_model.sv
// Behavioural TDM line: line clock, frame sync, serial data and out-of-frame pins
`timescale 1ns/1ps
`default_nettype none
module tdm_line_model (
  input  wire logic        run_in,
  input  wire logic        rise_in,
  input  wire logic        data_in,
  input  wire logic        oof_in,
  input  wire logic [31:0] sync_a_in,
  input  wire logic [31:0] sync_b_in,
  output logic             clk_out,
  output logic             data_out,
  output logic             sync_out,
  output logic             oof_out,
  output int               bits_out
);
  // ****
  // Bit loop
  // ****
  // Pins are valid only around the sampling edge and inverted elsewhere,
  // so a receiver using the other edge reads the wrong level
  always begin
    clk_out = 1'b0;
    data_out = 1'b0;
    sync_out = 1'b0;
    oof_out = 1'b0;
    bits_out = 0;
    wait (run_in === 1'b1);
    while (run_in === 1'b1) begin
      clk_out = !rise_in;
      #60;
      data_out = data_in;
      sync_out = (bits_out == sync_a_in) || (bits_out == sync_b_in);
      oof_out = oof_in;
      #20;
      clk_out = rise_in;
      bits_out = bits_out + 1;
      #60;
      data_out = !data_out;
      sync_out = !sync_out;
      oof_out = !oof_out;
      #20;
    end
  end
endmodule : tdm_line_model
`default_nettype wire

// ### tb/tdm_serial_port_config_tb.sv
// Self-checking bench for the TDM serial port configuration block
`timescale 1ns/1ps
`default_nettype none
module tdm_serial_port_config_tb;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic        tx_bit_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [6:0]  rx_slot_out;
  logic        tx_serial_data_out, tx_serial_data_oe_out, tx_bit_take_out, rx_bit_out, rx_bit_valid_out;
  logic        rx_clk, rx_dat, rx_sync, rx_oofp, tx_clk, tx_sync;
  logic        rx_run = 1'b0, rx_rise = 1'b0, rx_data = 1'b0, rx_oof = 1'b0, tx_run = 1'b0, tx_rise = 1'b0;
  logic        dedge = 1'b0, tedge = 1'b0, oe_q = 1'b0, one_q = 1'b0;
  logic [31:0] rx_sa = 32'h0000_0002, rx_sb = 32'hFFFF_FFFF, tx_sa = 32'h0000_0004, tx_sb = 32'h0000_0018;
  int          rx_bits, tx_bits, fails = 0, samples_checked = 0, cycles = 0, n_take = 0, n_rise = 0, n_fall = 0;

  always #5 clk_in = ~clk_in;

  tdm_line_model u_tdm_line_model_rx (.run_in(rx_run), .rise_in(rx_rise), .data_in(rx_data), .oof_in(rx_oof),
    .sync_a_in(rx_sa), .sync_b_in(rx_sb), .clk_out(rx_clk), .data_out(rx_dat), .sync_out(rx_sync),
    .oof_out(rx_oofp), .bits_out(rx_bits));
  tdm_line_model u_tdm_line_model_tx (.run_in(tx_run), .rise_in(tx_rise), .data_in(1'b0), .oof_in(1'b0),
    .sync_a_in(tx_sa), .sync_b_in(tx_sb), .clk_out(tx_clk), .data_out(), .sync_out(tx_sync),
    .oof_out(), .bits_out(tx_bits));
  tdm_serial_port_config u_tdm_serial_port_config (.clk_in(clk_in), .nrst_in(nrst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .rx_line_clock_in(rx_clk), .rx_serial_data_in(rx_dat),
    .rx_frame_sync_input_in(rx_sync), .out_of_frame_input_in(rx_oofp), .tx_line_clock_in(tx_clk),
    .tx_frame_sync_input_in(tx_sync), .tx_serial_data_out(tx_serial_data_out),
    .tx_serial_data_oe_out(tx_serial_data_oe_out), .tx_bit_in(tx_bit_in), .tx_bit_take_out(tx_bit_take_out),
    .rx_bit_out(rx_bit_out), .rx_bit_valid_out(rx_bit_valid_out), .rx_slot_out(rx_slot_out));

  // ****
  // Checking and bus tasks
  // ****
  task automatic final_report;
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk32

  task automatic chk1(input string n, input logic e, input logic g);
    chk32(n, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask : rd

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk32(n, e, d);
  endtask : rdchk

  // Lands mid-bit, after the receive pulse and before the next sampling edge
  task automatic at_bit(input int n);
    wait ((rx_run ? rx_bits : tx_bits) >= n);
    repeat (10) @(posedge clk_in);
    #1;
  endtask : at_bit

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      fails++;
      final_report;
    end
    if (rx_bit_valid_out === 1'b1) begin
      chk1("rx clock level", dedge, rx_clk);
      chk1("rx bit", rx_data, rx_bit_out);
    end
    if (tx_bit_take_out === 1'b1) begin
      n_take <= n_take + 1;
      chk1("tx clock level", tedge, tx_clk);
    end
    oe_q <= tx_serial_data_oe_out;
    one_q <= tx_serial_data_oe_out & tx_serial_data_out;
    if (tx_serial_data_oe_out === 1'b1 && oe_q === 1'b0) n_rise <= n_rise + 1;
    if ((tx_serial_data_oe_out & tx_serial_data_out) === 1'b0 && one_q === 1'b1) n_fall <= n_fall + 1;
  end

  // ****
  // Scenarios
  // ****
  task automatic reg_test;
    rdchk("guard", 8'h00, 32'h0000_0000);
    rdchk("port", 8'h04, 32'h0000_0000);
    wr(8'h04, 32'hFFFF_FFFF);
    rdchk("port", 8'h04, 32'h0000_03F7);
    wr(8'h00, 32'hFFFF_FFFF);
    rdchk("guard", 8'h00, 32'h8FFF_0FFF);
    wr(8'h00, 32'h0FFF_0FFF);
    rdchk("guard", 8'h00, 32'h0FFF_0FFF);
    wr(8'h40, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'h40, 32'h0000_0000);
    wr(8'h08, 32'h0000_0004);
    rdchk("control", 8'h08, 32'h0000_0004);
    wr(8'h08, 32'h0000_0009);
    rdchk("control", 8'h08, 32'h0000_0009);
  endtask : reg_test

  task automatic rx_mode(input logic [2:0] m, input int slots, input logic e);
    logic [31:0] d;
    rx_rise = e;
    dedge = e;
    rx_data = ~e;
    rx_oof = e;
    rx_sb = 32'hFFFF_FFFF;
    wr(8'h04, {23'h00_0000, e, e, e, 3'h0, m});
    rx_run = 1'b1;
    at_bit(2 + 8 * slots);
    chk32("rx last slot", 32'(slots - 1), {25'h000_0000, rx_slot_out});
    at_bit(3 + 8 * slots);
    chk32("rx wrap slot", 32'h0000_0000, {25'h000_0000, rx_slot_out});
    rd(8'h0C, d);
    chk1("oof state", e, d[1]);
    rx_run = 1'b0;
    repeat (40) @(posedge clk_in);
  endtask : rx_mode

  task automatic rx_align(input logic [2:0] m, input logic f);
    logic [31:0] d;
    rx_rise = 1'b0;
    dedge = 1'b0;
    rx_data = 1'b1;
    rx_sb = 32'h0000_002D;
    wr(8'h04, {29'h0000_0000, m});
    rx_run = 1'b1;
    at_bit(10);
    wr(8'h0C, 32'h0000_0001);
    rd(8'h0C, d);
    chk1("align change", 1'b0, d[0]);
    at_bit(46);
    chk32("rx sync slot", 32'h0000_0000, {25'h000_0000, rx_slot_out});
    rd(8'h0C, d);
    chk1("align change", f, d[0]);
    rx_run = 1'b0;
    repeat (40) @(posedge clk_in);
  endtask : rx_align

  task automatic tx_case(input logic t9, input logic e4, input logic e5, input logic en,
                         input logic [31:0] takes, input logic [31:0] rises, input logic [31:0] falls);
    wr(8'h10, 32'h0000_0001);
    wr(8'h08, {30'h0000_0000, en, 1'b1});
    wr(8'h04, {22'h00_0000, t9, 3'h0, e5, e4, 4'h0});
    tedge = e4;
    tx_rise = e5;
    tx_run = 1'b1;
    at_bit(14);
    n_take = 0;
    n_rise = 0;
    n_fall = 0;
    at_bit(300);
    chk32("tx takes", takes, n_take);
    chk32("oe rises", rises, n_rise);
    chk32("one falls", falls, n_fall);
    tx_run = 1'b0;
    repeat (40) @(posedge clk_in);
    rdchk("tx map", 8'h10, 32'h0000_0001);
  endtask : tx_case

  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    reg_test;
    rx_mode(3'h0, 24, 1'b0);
    rx_mode(3'h1, 32, 1'b1);
    rx_mode(3'h2, 64, 1'b0);
    rx_mode(3'h3, 128, 1'b1);
    rx_align(3'h1, 1'b1);
    rx_align(3'h4, 1'b0);
    tx_case(1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_0010, 32'h0000_0002, 32'h0000_0000);
    tx_case(1'b1, 1'b1, 1'b0, 1'b1, 32'h0000_0010, 32'h0000_0000, 32'h0000_0002);
    tx_case(1'b1, 1'b1, 1'b1, 1'b0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    final_report;
  end
endmodule : tdm_serial_port_config_tb
`default_nettype wire
